// File: hdl/csb_regs.vh
`ifndef CSB_REGS_VH
`define CSB_REGS_VH

// register byte offsets on the wishbone slave
`define CSB_OFS_SWAP_DATA   8'h0c
`define CSB_OFS_SWAP_CMP    8'h10
`define CSB_OFS_SWAP_CTRL   8'h14
`define CSB_OFS_ROM_HDR     8'h18
`define CSB_OFS_BUS_ID      8'h1c
`define CSB_OFS_BUS_OPT     8'h20
`define CSB_OFS_DATA_LOAD   8'h30
`define CSB_OFS_CMP_LOAD    8'h34
`define CSB_OFS_OLD_VAL     8'h38
`define CSB_OFS_IRQ_STAT    8'h40
`define CSB_OFS_IRQ_MASK    8'h44

// swap control layout
`define CSB_CTRL_DONE_BIT   31
`define CSB_CTRL_SEL_MSB    1
`define CSB_CTRL_SEL_LSB    0
`define CSB_CTRL_RST_DONE   1'b1
`define CSB_CTRL_RST_SEL    2'h0

// resource select codes
`define CSB_SEL_BUS_MGR     2'h0
`define CSB_SEL_BANDWIDTH   2'h1
`define CSB_SEL_CHAN_HI     2'h2
`define CSB_SEL_CHAN_LO     2'h3

// fixed and writable field masks
`define CSB_BUS_ID_VALUE    32'h31333934
`define CSB_HDR_RST         32'h00000000
`define CSB_OPT_RW_MASK     32'hf8ff0000
`define CSB_OPT_RST         32'h00000000
`define CSB_OPT_LOW_MASK    32'h0000ffff

// configuration rom quadlet index seen by remote nodes
`define CSB_ROM_Q_HDR       2'h0
`define CSB_ROM_Q_BUS_ID    2'h1
`define CSB_ROM_Q_BUS_OPT   2'h2

// interrupt status bits
`define CSB_IRQ_DONE_BIT    0
`define CSB_IRQ_MATCH_BIT   1
`define CSB_IRQ_WIDTH       2
`define CSB_IRQ_RST         2'h0

// swap engine states
`define CSB_ST_IDLE         2'h0
`define CSB_ST_FETCH        2'h1
`define CSB_ST_SWAP         2'h2
`define CSB_ST_DONE         2'h3

`endif

// File: hdl/csb_swap_engine.v
`timescale 1ns/1ns
`include "csb_regs.vh"

module csb_swap_engine #(
  parameter WIDTH        = 32,
  parameter RST_BUS_MGR  = 32'hffffffff,
  parameter RST_BANDWID  = 32'hffffffff,
  parameter RST_CHAN_HI  = 32'hffffffff,
  parameter RST_CHAN_LO  = 32'hffffffff
) (
  input  wire             i_clk,
  input  wire             i_rst,
  input  wire             i_start,
  input  wire [1:0]       i_sel,
  input  wire [WIDTH-1:0] i_compare,
  input  wire [WIDTH-1:0] i_data,
  output reg              o_busy,
  output reg              o_done,
  output reg              o_match,
  output reg  [WIDTH-1:0] o_old
);

  localparam ST_IDLE  = `CSB_ST_IDLE;
  localparam ST_FETCH = `CSB_ST_FETCH;
  localparam ST_SWAP  = `CSB_ST_SWAP;
  localparam ST_DONE  = `CSB_ST_DONE;

  reg [WIDTH-1:0] res [0:3];
  reg [1:0]       state;
  reg [1:0]       sel;
  reg [WIDTH-1:0] cmp;
  reg [WIDTH-1:0] data;

  // operands are latched at start so later register writes cannot disturb a swap
  always @(posedge i_clk) begin
    if (i_rst) begin
      state   <= ST_IDLE;
      sel     <= `CSB_SEL_BUS_MGR;
      cmp     <= {WIDTH{1'b0}};
      data    <= {WIDTH{1'b0}};
      o_old   <= {WIDTH{1'b0}};
      o_busy  <= 1'b0;
      o_done  <= 1'b0;
      o_match <= 1'b0;
      res[0]  <= RST_BUS_MGR;
      res[1]  <= RST_BANDWID;
      res[2]  <= RST_CHAN_HI;
      res[3]  <= RST_CHAN_LO;
    end else begin
      o_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (i_start) begin
            sel    <= i_sel;
            cmp    <= i_compare;
            data   <= i_data;
            o_busy <= 1'b1;
            state  <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          o_old <= res[sel];
          state <= ST_SWAP;
        end
        ST_SWAP: begin
          // replace only when the present value matches the compare value
          if (o_old == cmp) begin
            res[sel] <= data;
            o_match  <= 1'b1;
          end else begin
            o_match  <= 1'b0;
          end
          state <= ST_DONE;
        end
        ST_DONE: begin
          o_done <= 1'b1;
          o_busy <= 1'b0;
          state  <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// File: hdl/csb_top.v
`timescale 1ns/1ns
`include "csb_regs.vh"

module csb_top #(
  parameter WIDTH       = 32,
  parameter ADR_W       = 8,
  parameter OPT_LOW     = 16'hb003,
  parameter RST_BUS_MGR = 32'hffffffff,
  parameter RST_BANDWID = 32'hffffffff,
  parameter RST_CHAN_HI = 32'hffffffff,
  parameter RST_CHAN_LO = 32'hffffffff
) (
  input  wire             i_clk,
  input  wire             i_rst,
  input  wire             i_wb_cyc,
  input  wire             i_wb_stb,
  input  wire             i_wb_we,
  input  wire [ADR_W-1:0] i_wb_adr,
  input  wire [3:0]       i_wb_sel,
  input  wire [WIDTH-1:0] i_wb_dat,
  output reg  [WIDTH-1:0] o_wb_dat,
  output reg              o_wb_ack,
  input  wire             i_rom_rd,
  input  wire [1:0]       i_rom_idx,
  output reg  [WIDTH-1:0] o_rom_data,
  output reg              o_rom_valid,
  output reg              o_irq
);

  // merge write data into a register under the byte enables
  // lanes left low keep their old byte, so a narrow write touches one field only
  function [31:0] csb_merge;
    input [31:0] old_val;
    input [31:0] wr_val;
    input [3:0]  lanes;
    integer k;
    begin
      csb_merge = old_val;
      for (k = 0; k < 4; k = k + 1) begin
        if (lanes[k]) begin
          csb_merge[k*8 +: 8] = wr_val[k*8 +: 8];
        end
      end
    end
  endfunction

  // host visible storage and the registered read paths
  reg  [WIDTH-1:0]          swap_data;
  reg  [WIDTH-1:0]          swap_compare_value;
  reg                       swap_done_flag;
  reg  [1:0]                resource_select;
  reg  [WIDTH-1:0]          rom_header_quadlet;
  reg  [WIDTH-1:0]          bus_options_quadlet;
  reg  [`CSB_IRQ_WIDTH-1:0] irq_status;
  reg  [`CSB_IRQ_WIDTH-1:0] irq_mask;
  reg  [`CSB_IRQ_WIDTH-1:0] next_irq_status;
  reg  [WIDTH-1:0]          next_rd_data;
  reg  [WIDTH-1:0]          next_rom_data;
  reg                       swap_start;

  // engine results and decoded write strobes
  wire                      eng_busy;
  wire                      eng_done;
  wire                      eng_match;
  wire [WIDTH-1:0]          eng_old;
  wire [WIDTH-1:0]          ctrl_word;
  wire [WIDTH-1:0]          opt_word;
  wire [WIDTH-1:0]          bus_id_word;
  wire [ADR_W-1:0]          word_adr;
  wire                      wb_req;
  wire                      wb_wr;
  wire                      wr_ctrl;
  wire                      wr_data_ld;
  wire                      wr_cmp_ld;
  wire                      wr_hdr;
  wire                      wr_opt;
  wire                      wr_irq_stat;
  wire                      wr_irq_mask;

  // ack is given once per request; the gap after ack keeps a held request single
  // a master that holds its strobe through ack still gets exactly one transfer
  assign wb_req   = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wb_wr    = wb_req & i_wb_we;
  assign word_adr = {i_wb_adr[ADR_W-1:2], 2'b00};
  assign wr_ctrl  = wb_wr & (word_adr == `CSB_OFS_SWAP_CTRL) & (|i_wb_sel);

  // one strobe per writable offset; each block below reads only its own
  // strobe, so a new offset cannot alias onto an existing register by accident
  assign wr_data_ld  = wb_wr & (word_adr == `CSB_OFS_DATA_LOAD);
  assign wr_cmp_ld   = wb_wr & (word_adr == `CSB_OFS_CMP_LOAD);
  assign wr_hdr      = wb_wr & (word_adr == `CSB_OFS_ROM_HDR);
  assign wr_opt      = wb_wr & (word_adr == `CSB_OFS_BUS_OPT);
  assign wr_irq_stat = wb_wr & (word_adr == `CSB_OFS_IRQ_STAT) & i_wb_sel[0];
  assign wr_irq_mask = wb_wr & (word_adr == `CSB_OFS_IRQ_MASK) & i_wb_sel[0];

  // swap control readback; bits 30 to 2 are tied low
  // select sits in the low two bits, the done flag in the top bit
  assign ctrl_word = {swap_done_flag, {(WIDTH-3){1'b0}}, resource_select};

  // bus options: writable flags and accuracy, reserved bits zero, low half fixed
  // masking at readback means no stored value can leak into reserved bits
  assign opt_word = (bus_options_quadlet & `CSB_OPT_RW_MASK) |
                    ({{(WIDTH-16){1'b0}}, OPT_LOW} & `CSB_OPT_LOW_MASK);
  assign bus_id_word = `CSB_BUS_ID_VALUE;

  // swap engine: operands are latched at start, done pulses three cycles later
  // a control write taken while busy only clears done and moves the select;
  // the running swap keeps its own copy of the select and still reports done
  csb_swap_engine #(
    .WIDTH       (WIDTH),
    .RST_BUS_MGR (RST_BUS_MGR),
    .RST_BANDWID (RST_BANDWID),
    .RST_CHAN_HI (RST_CHAN_HI),
    .RST_CHAN_LO (RST_CHAN_LO)
  ) u_engine (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_start   (swap_start),
    .i_sel     (resource_select),
    .i_compare (swap_compare_value),
    .i_data    (swap_data),
    .o_busy    (eng_busy),
    .o_done    (eng_done),
    .o_match   (eng_match),
    .o_old     (eng_old)
  );

  // wishbone handshake: single wait state, reads registered with ack
  // read data is captured only on reads, so a write leaves the last read visible
  // ack comes straight from a flop, which costs the one wait state
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= {WIDTH{1'b0}};
    end else begin
      o_wb_ack <= wb_req;
      if (wb_req & ~i_wb_we) begin
        o_wb_dat <= next_rd_data;
      end
    end
  end

  // read mux; unmapped offsets answer with zero rather than an error
  // the low address bits are ignored, every register is one aligned word
  // write-only load offsets read zero; their values show at the read-only views
  always @* begin
    next_rd_data = {WIDTH{1'b0}};
    case (word_adr)
      `CSB_OFS_SWAP_DATA: next_rd_data = swap_data;
      `CSB_OFS_SWAP_CMP:  next_rd_data = swap_compare_value;
      `CSB_OFS_SWAP_CTRL: next_rd_data = ctrl_word;
      `CSB_OFS_ROM_HDR:   next_rd_data = rom_header_quadlet;
      `CSB_OFS_BUS_ID:    next_rd_data = bus_id_word;
      `CSB_OFS_BUS_OPT:   next_rd_data = opt_word;
      `CSB_OFS_OLD_VAL:   next_rd_data = eng_old;
      `CSB_OFS_IRQ_STAT:  next_rd_data = {{(WIDTH-`CSB_IRQ_WIDTH){1'b0}}, irq_status};
      `CSB_OFS_IRQ_MASK:  next_rd_data = {{(WIDTH-`CSB_IRQ_WIDTH){1'b0}}, irq_mask};
      default:            next_rd_data = {WIDTH{1'b0}};
    endcase
  end

  // operand registers; compare is loaded only through its load port so the
  // read-only view cannot be changed mid-swap by a stray write to its offset
  // the engine copies both operands at start, so reloading them early is safe
  always @(posedge i_clk) begin
    if (i_rst) begin
      swap_data          <= {WIDTH{1'b0}};
      swap_compare_value <= {WIDTH{1'b0}};
    end else begin
      if (wr_data_ld) begin
        swap_data <= csb_merge(swap_data, i_wb_dat, i_wb_sel);
      end
      if (wr_cmp_ld) begin
        swap_compare_value <= csb_merge(swap_compare_value, i_wb_dat, i_wb_sel);
      end
    end
  end

  // swap control: a write selects the resource and launches a swap when idle
  // a start while busy is dropped; the running swap still reports done
  // start is a one-cycle pulse so a held request cannot launch twice
  always @(posedge i_clk) begin
    if (i_rst) begin
      swap_done_flag  <= `CSB_CTRL_RST_DONE;
      resource_select <= `CSB_CTRL_RST_SEL;
      swap_start      <= 1'b0;
    end else begin
      swap_start <= 1'b0;
      if (wr_ctrl & i_wb_sel[0]) begin
        resource_select <= i_wb_dat[`CSB_CTRL_SEL_MSB:`CSB_CTRL_SEL_LSB];
      end
      if (wr_ctrl & ~eng_busy) begin
        swap_start <= 1'b1;
      end
      // completion beats a clear landing in the same cycle
      if (eng_done) begin
        swap_done_flag <= 1'b1;
      end else if (wr_ctrl) begin
        swap_done_flag <= 1'b0;
      end
    end
  end

  // rom header fields are plain storage; validity while linked is software's job
  // the check value has no defined reset; zero keeps the readback clean
  // remote nodes see a write in the next strobe, there is no shadow copy
  always @(posedge i_clk) begin
    if (i_rst) begin
      rom_header_quadlet <= `CSB_HDR_RST;
    end else if (wr_hdr) begin
      rom_header_quadlet <= csb_merge(rom_header_quadlet, i_wb_dat, i_wb_sel);
    end
  end

  // bus options keep only the writable bits; reserved bits never store
  // the fixed low half is merged at readback, not stored, so it cannot drift
  // lane writes are allowed, each lane lands on its own field
  always @(posedge i_clk) begin
    if (i_rst) begin
      bus_options_quadlet <= `CSB_OPT_RST;
    end else if (wr_opt) begin
      bus_options_quadlet <= csb_merge(bus_options_quadlet, i_wb_dat, i_wb_sel) &
                             `CSB_OPT_RW_MASK;
    end
  end

  // remote quadlet read mux; index 3 lies past the served block and reads zero
  // remote reads share the fields of the host view, so both always agree
  // the index is from logic on this clock, so it needs no synchroniser
  always @* begin
    next_rom_data = {WIDTH{1'b0}};
    case (i_rom_idx)
      `CSB_ROM_Q_HDR:     next_rom_data = rom_header_quadlet;
      `CSB_ROM_Q_BUS_ID:  next_rom_data = bus_id_word;
      `CSB_ROM_Q_BUS_OPT: next_rom_data = opt_word;
      default:            next_rom_data = {WIDTH{1'b0}};
    endcase
  end

  // remote read answer one cycle after the strobe; data holds until the next one
  // the link side takes valid and data together in the cycle after its strobe
  // back to back strobes are served every cycle, no busy state is needed
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_rom_data  <= {WIDTH{1'b0}};
      o_rom_valid <= 1'b0;
    end else begin
      o_rom_valid <= i_rom_rd;
      if (i_rom_rd) begin
        o_rom_data <= next_rom_data;
      end
    end
  end

  // sticky status: a new event wins over a write-one-to-clear in the same cycle
  // the clear uses lane 0 only; the other lanes carry no status bits
  // losing an event would hide a finished swap from software for good
  always @* begin
    next_irq_status = irq_status;
    if (wr_irq_stat) begin
      next_irq_status = irq_status & ~i_wb_dat[`CSB_IRQ_WIDTH-1:0];
    end
    if (eng_done) begin
      next_irq_status[`CSB_IRQ_DONE_BIT] = 1'b1;
    end
    if (eng_done & eng_match) begin
      next_irq_status[`CSB_IRQ_MATCH_BIT] = 1'b1;
    end
  end

  // status, mask and the level interrupt line
  // the line is built from next status so it rises with the status bit
  // a new mask takes effect on the line one cycle after the write
  always @(posedge i_clk) begin
    if (i_rst) begin
      irq_status <= `CSB_IRQ_RST;
      irq_mask   <= `CSB_IRQ_RST;
      o_irq      <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      if (wr_irq_mask) begin
        irq_mask <= i_wb_dat[`CSB_IRQ_WIDTH-1:0];
      end
      o_irq <= |(next_irq_status & irq_mask);
    end
  end

endmodule

// File: dv/csb_top_checker.sv
`timescale 1ns/1ns
module csb_top_checker #(
  parameter WIDTH   = 32,
  parameter ADR_W   = 8,
  parameter OPT_LOW = 16'hb003
) (
  input wire             i_clk,
  input wire             i_rst,
  input wire             i_wb_cyc,
  input wire             i_wb_stb,
  input wire             i_wb_we,
  input wire [ADR_W-1:0] i_wb_adr,
  input wire [WIDTH-1:0] o_wb_dat,
  input wire             o_wb_ack,
  input wire             i_rom_rd,
  input wire [1:0]       i_rom_idx,
  input wire [WIDTH-1:0] o_rom_data,
  input wire             o_rom_valid
);
  // a request counts only while no ack is pending, so a held strobe is not taken twice
  wire take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire rd_take = take && !i_wb_we;
  wire rom_rd = i_rom_rd;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_ack_answer; take |=> o_wb_ack; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack after request");
  property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_rd_busid; rd_take && i_wb_adr == 8'h1c |=> o_wb_dat == 32'h31333934; endproperty
  a_rd_busid: assert property (p_rd_busid) else $error("bus id read wrong");
  property p_rd_rsvd; rd_take && i_wb_adr == 8'h14 |=> o_wb_dat[30:2] == 29'h0; endproperty
  a_rd_rsvd: assert property (p_rd_rsvd) else $error("control reserved bits set");
  property p_rd_opt;
    rd_take && i_wb_adr == 8'h20 |=> o_wb_dat[15:0] == OPT_LOW && o_wb_dat[26:24] == 3'h0;
  endproperty
  a_rd_opt: assert property (p_rd_opt) else $error("bus options fixed bits wrong");
  property p_rom_busid; rom_rd && i_rom_idx == 2'h1 |=> o_rom_data == 32'h31333934; endproperty
  a_rom_busid: assert property (p_rom_busid) else $error("remote bus id wrong");
  property p_rom_valid; rom_rd |=> o_rom_valid; endproperty
  a_rom_valid: assert property (p_rom_valid) else $error("remote answer timing wrong");
  property p_rom_quiet; !rom_rd |=> !o_rom_valid; endproperty
  a_rom_quiet: assert property (p_rom_quiet) else $error("remote valid without strobe");
endmodule
bind csb_top csb_top_checker #(.WIDTH(WIDTH), .ADR_W(ADR_W), .OPT_LOW(OPT_LOW)) u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_rom_rd(i_rom_rd), .i_rom_idx(i_rom_idx), .o_rom_data(o_rom_data),
  .o_rom_valid(o_rom_valid));

// File: dv/csb_top_tb.sv
`timescale 1ns/1ns
module csb_top_tb;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        rom_rd  = 1'b0;
  logic [1:0]  rom_idx = 2'h0;
  logic [31:0] rom_q;
  logic        rom_v;
  logic        irq;
  integer      fail_count = 0;
  integer      n_compared = 0;
  integer      s;

  always #10 i_clk = ~i_clk;

  csb_top u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_rom_rd(rom_rd), .i_rom_idx(rom_idx), .o_rom_data(rom_q), .o_rom_valid(rom_v),
    .o_irq(irq));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task final_report;
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // classic cycle: held until ack is sampled, released at that edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] m,
           output logic [31:0] q);
    @(posedge i_clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= m;
    // no assumed latency: only the watchdog ends a wait that never sees ack
    do begin
      @(posedge i_clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] m);
    logic [31:0] q;
    bus(1'b1, a, d, m, q);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(q, exp);
  endtask

  // one remote quadlet read; valid is looked at in its single cycle
  task romc(input logic [1:0] i, input logic [31:0] exp);
    @(posedge i_clk);
    rom_rd <= 1'b1;
    rom_idx <= i;
    @(posedge i_clk);
    rom_rd <= 1'b0;
    @(posedge i_clk);
    chk({31'h0, rom_v}, 32'h1);
    chk(rom_q, exp);
  endtask

  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    rdc(8'h14, 32'h80000000);
    rdc(8'h18, 32'h0);
    rdc(8'h1c, 32'h31333934);
    rdc(8'h20, 32'h0000b003);
    wr(8'h10, 32'hffffffff, 4'hf);
    rdc(8'h10, 32'h0);
    wr(8'h1c, 32'h0, 4'hf);
    rdc(8'h1c, 32'h31333934);
    rdc(8'h7c, 32'h0);
    wr(8'h18, 32'ha5c31234, 4'hf);
    wr(8'h18, 32'h5a0000ff, 4'h8);
    rdc(8'h18, 32'h5ac31234);
    romc(2'h0, 32'h5ac31234);
    romc(2'h1, 32'h31333934);
    wr(8'h20, 32'hffffffff, 4'hf);
    rdc(8'h20, 32'hf8ffb003);
    romc(2'h2, 32'hf8ffb003);
    romc(2'h3, 32'h0);
    wr(8'h34, 32'hffffffff, 4'hf);
    rdc(8'h10, 32'hffffffff);
    // each resource starts all ones, so a wrong select shows up as a stale old value
    for (s = 0; s < 4; s = s + 1) begin
      wr(8'h30, 32'h100 + s, 4'hf);
      wr(8'h14, 32'h80000000 | s, 4'hf);
      rdc(8'h14, s);
      repeat (6) @(posedge i_clk);
      rdc(8'h14, 32'h80000000 | s);
      rdc(8'h38, 32'hffffffff);
      wr(8'h14, s, 4'h1);
      repeat (6) @(posedge i_clk);
      rdc(8'h38, 32'h100 + s);
    end
    chk({31'h0, irq}, 32'h0);
    rdc(8'h40, 32'h3);
    wr(8'h44, 32'h1, 4'h1);
    repeat (2) @(posedge i_clk);
    chk({31'h0, irq}, 32'h1);
    wr(8'h40, 32'h1, 4'h1);
    repeat (2) @(posedge i_clk);
    chk({31'h0, irq}, 32'h0);
    rdc(8'h40, 32'h2);
    final_report;
  end

  // the run needs about 200 cycles; this is a wide margin
  initial begin
    #100000;
    fail_count = fail_count + 1;
    final_report;
  end
endmodule
